// ---- bench/async_line_chk.sv ----
// Port-level assertion checker for the asynchronous line interface
`timescale 1ns/10ps
module async_line_chk
   import async_line_pkg::*;
#(
   parameter logic [1:0] BR_LEVEL = 2'h0
) (
   input wire logic        core_clk,
   input wire logic        resetn,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        tx_line,
   input wire logic        modem_dtr,
   input wire logic        tx_irq,
   input wire logic [1:0]  br_level
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic wr_hs;
   logic rd_hs;
   assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign rd_hs = s_axi_arvalid && s_axi_arready;
   // ==========================
   // Register write of one bit
   sequence s_wr(a, m, v);
      wr_hs && s_axi_awaddr == a && s_axi_wstrb[0] && s_axi_wdata[m] == v;
   endsequence
   property p_level; br_level == BR_LEVEL; endproperty
   property p_wresp; wr_hs |-> ##2 s_axi_bvalid; endproperty
   property p_rresp; rd_hs |-> ##2 s_axi_rvalid; endproperty
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_slverr; rd_hs && s_axi_araddr > CFG_ADDR |-> ##2 s_axi_rresp == RESP_SLVERR;
   endproperty
   property p_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   property p_brk; s_wr(8'h08, 0, 1'b1) |-> ##2 !tx_line [*4]; endproperty
   property p_dtr; s_wr(8'h00, 1, 1'b1) |-> ##2 modem_dtr; endproperty
   property p_txie; s_wr(8'h08, 6, 1'b0) |-> ##2 !tx_irq; endproperty
   a_level: assert property (p_level) else $error("priority level differs");
   a_wresp: assert property (p_wresp) else $error("write answer late");
   a_rresp: assert property (p_rresp) else $error("read answer late");
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   a_slverr: assert property (p_slverr) else $error("bad address accepted");
   a_refuse: assert property (p_refuse) else $error("write taken while busy");
   a_brk: assert property (p_brk) else $error("line not at space");
   a_dtr: assert property (p_dtr) else $error("terminal ready not driven");
   a_txie: assert property (p_txie) else $error("request without enable");
endmodule : async_line_chk
bind async_line_interface async_line_chk #(.BR_LEVEL(BR_LEVEL)) i_chk (.core_clk, .resetn,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_line, .modem_dtr, .tx_irq, .br_level);

// ---- bench/async_line_interface_tb_top.sv ----
// Self-checking bench for the asynchronous line interface
`timescale 1ns/10ps
module async_line_interface_tb_top
   import async_line_pkg::*;
;
   logic        core_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, rx_line, tx_line, modem_sec_rx, modem_carrier, modem_ring;
   logic        modem_cts, modem_dtr, modem_rts, modem_sec_tx, rx_irq, tx_irq, modem_irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, br_level, rr;
   int          miscompares, n_tests, cycles, n;
   async_line_interface #(.BR_LEVEL(2'h2), .DIV_BASE(16'h0001)) i_dut (.core_clk, .resetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_line,
      .tx_line, .modem_sec_rx, .modem_carrier, .modem_ring, .modem_cts, .modem_dtr, .modem_rts,
      .modem_sec_tx, .rx_irq, .tx_irq, .modem_irq, .br_level);
   line_partner i_line (.tx_line, .rx_line, .modem_sec_rx, .modem_carrier,
      .modem_ring, .modem_cts);
   // ==========================
   // Bus tasks and checks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      b = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      while (!b) begin
         @(negedge core_clk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid && s_axi_bready;
         rr = s_axi_bresp;
         @(posedge core_clk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) s_axi_bready <= 1'b0;
      end
      @(posedge core_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic ar, r;
      r = 1'b0;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      while (!r) begin
         @(negedge core_clk);
         ar = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         rr = s_axi_rresp;
         @(posedge core_clk);
         if (ar) s_axi_arvalid <= 1'b0;
         if (r) s_axi_rready <= 1'b0;
      end
      @(posedge core_clk);
   endtask : rd
   task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      rd(a, rv);
      chk(rv & m, exp);
   endtask : rc
   task automatic poll(input logic [7:0] a, input int b);
      rv = 32'h0;
      for (int i = 0; i < 500 && !rv[b]; i++) rd(a, rv);
   endtask : poll
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   // ==========================
   // Clock, timeout and test sequence
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         miscompares++;
         report_and_stop;
      end
   end
   initial begin
      {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cycles} = '0;
      s_axi_wstrb = 4'h3;
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      rc(8'h08, 32'h80, 32'hFFFF_FFFF);
      rc(8'h10, 32'h0377, 32'hFFFF_FFFF);
      rd(8'h14, rv);
      chk(rr, RESP_SLVERR);
      wr(8'h10, 32'h0300);
      wr(8'h0C, 32'h5A);
      poll(8'h08, TX_RDY_BIT);
      wr(8'h0C, 32'hA5);
      rc(8'h08, 32'h0, 32'h80);
      for (n = 0; n < 1000 && i_line.got.size() < 2; n++) @(posedge core_clk);
      chk(i_line.got[0], 8'h5A);
      chk(i_line.got[1], 8'hA5);
      wr(8'h00, 32'h006E);
      chk({modem_dtr, modem_rts, modem_sec_tx}, 3'b111);
      i_line.send(8'h3C, 1'b0, 1'b0);
      poll(8'h00, RX_DONE_BIT);
      chk(rx_irq, 1'b1);
      rc(8'h04, 32'h3C, 32'hFFFF);
      chk(rx_irq, 1'b0);
      wr(8'h10, 32'h0700);
      i_line.send(8'h3C, 1'b1, 1'b1);
      poll(8'h00, RX_DONE_BIT);
      rc(8'h04, 32'h903C, 32'hF0FF);
      i_line.modem(4'hF);
      repeat (4) @(posedge core_clk);
      chk(modem_irq, 1'b1);
      rc(8'h00, 32'hF46E, 32'hFFFF);
      rc(8'h00, 32'h746E, 32'hFFFF);
      chk(modem_irq, 1'b0);
      wr(8'h08, 32'h40);
      chk(tx_irq, 1'b1);
      wr(8'h08, 32'h00);
      s_axi_wstrb <= 4'h1;
      wr(8'h10, 32'hFF70);
      s_axi_wstrb <= 4'h3;
      rc(8'h10, 32'h0770, 32'hFFFF);
      wr(8'h08, 32'h04);
      i_line.space(1'b1);
      wr(8'h0C, 32'h96);
      poll(8'h00, RX_DONE_BIT);
      rc(8'h04, 32'h96, 32'hFFFF);
      i_line.space(1'b0);
      wr(8'h08, 32'h00);
      wr(8'h10, 32'h0300);
      wr(8'h0C, 32'h00);
      wr(8'h08, 32'h01);
      wr(8'h0C, 32'h00);
      rc(8'h08, 32'h01, 32'h81);
      chk(tx_line, 1'b0);
      poll(8'h08, TX_RDY_BIT);
      chk(rv[TX_RDY_BIT], 1'b1);
      chk(tx_line, 1'b0);
      wr(8'h08, 32'h00);
      report_and_stop;
   end
endmodule : async_line_interface_tb_top

// ---- bench/line_partner.sv ----
// Serial terminal and modem model facing the line interface
`timescale 1ns/10ps
module line_partner #(
   parameter int BIT_NS = 64
) (
   input  wire logic tx_line,
   output logic      rx_line,
   output logic      modem_sec_rx,
   output logic      modem_carrier,
   output logic      modem_ring,
   output logic      modem_cts
);
   logic [7:0] got[$];
   logic [7:0] sh;
   initial begin
      rx_line = 1'b1;
      {modem_sec_rx, modem_carrier, modem_ring, modem_cts} = 4'h0;
   end
   // ==========================
   // Start, eight data bits low first, optional parity, one stop
   task automatic send(input logic [7:0] d, input logic pe, input logic flip);
      rx_line = 1'b0;
      #(BIT_NS);
      for (int i = 0; i < 8; i++) begin
         rx_line = d[i];
         #(BIT_NS);
      end
      if (pe) begin
         rx_line = ^d ^ flip;
         #(BIT_NS);
      end
      rx_line = 1'b1;
      #(BIT_NS);
   endtask : send
   task automatic space(input logic on);
      rx_line = !on;
   endtask : space
   task automatic modem(input logic [3:0] v);
      {modem_sec_rx, modem_carrier, modem_ring, modem_cts} = v;
   endtask : modem
   // ==========================
   // Receiver sampling mid-bit
   always begin
      @(negedge tx_line);
      #(BIT_NS / 2);
      for (int i = 0; i < 8; i++) begin
         #(BIT_NS);
         sh[i] = tx_line;
      end
      #(BIT_NS);
      got.push_back(sh);
   end
endmodule : line_partner

// ---- core/async_line_interface.sv ----
// Asynchronous serial line interface with AXI4-Lite register access
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module async_line_interface
   import async_line_pkg::*;
#(
   parameter bit          MODEM_EN  = 1'b1,
   parameter bit          BREAK_EN  = 1'b1,
   parameter logic [1:0]  BR_LEVEL  = 2'h0,
   parameter logic [15:0] DIV_BASE  = 16'h0004
) (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        rx_line,
   output logic             tx_line,
   input  wire logic        modem_sec_rx,
   input  wire logic        modem_carrier,
   input  wire logic        modem_ring,
   input  wire logic        modem_cts,
   output logic             modem_dtr,
   output logic             modem_rts,
   output logic             modem_sec_tx,
   output logic             rx_irq,
   output logic             tx_irq,
   output logic             modem_irq,
   output logic [1:0]       br_level
);
   // ==========================
   // Pin synchronisers
   logic [4:0] pin_s1_reg;
   logic [4:0] pin_s2_reg;
   logic [4:0] pin_prev_reg;
   logic [1:0] pin_age_reg;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         pin_s1_reg   <= 5'h1F;
         pin_s2_reg   <= 5'h1F;
         pin_prev_reg <= 5'h1F;
         pin_age_reg  <= 2'h0;
      end else begin
         if (pin_age_reg != 2'h3) pin_age_reg <= pin_age_reg + 2'h1;
         pin_s1_reg   <= {modem_cts, modem_ring, modem_carrier, modem_sec_rx, rx_line};
         pin_s2_reg   <= pin_s1_reg;
         pin_prev_reg <= pin_s2_reg;
      end
   end
   // ==========================
   // Control registers
   logic [15:0] cfg_reg;
   logic        rx_ie_reg, ds_ie_reg, tx_ie_reg, loop_reg, brk_reg;
   logic        dtr_reg, rts_reg, sec_tx_reg;
   logic        rx_done_reg, ds_int_reg, tx_rdy_reg;
   logic [7:0]  rx_data_reg, tx_hold_reg;
   logic        hold_full_reg;
   logic [3:0]  rx_err_reg;
   logic        wr_fire, rd_fire, aw_hold_reg, w_hold_reg;
   logic [7:0]  aw_addr_reg, ar_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   // Write channel: address and data taken in either order
   assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
   assign wr_fire       = aw_hold_reg && w_hold_reg;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         aw_hold_reg  <= 1'b0;
         w_hold_reg   <= 1'b0;
         aw_addr_reg  <= 8'h00;
         w_data_reg   <= 32'h0000_0000;
         w_strb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg > CFG_ADDR) ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // Write decode helpers
   function automatic logic is_reg(input logic [7:0] a, input logic [3:0] off);
      is_reg = (a[7:4] == 4'h0) && (a[3:0] == off);
   endfunction : is_reg
   logic wr_receive_control_status, wr_transmit_control_status, wr_transmit_buffer, wr_cfg, lo_en, hi_en;
   assign lo_en   = w_strb_reg[0];
   assign hi_en   = w_strb_reg[1];
   assign wr_receive_control_status = wr_fire && is_reg(aw_addr_reg, RX_CSR_OFF);
   assign wr_transmit_control_status = wr_fire && is_reg(aw_addr_reg, TX_CSR_OFF);
   assign wr_transmit_buffer = wr_fire && is_reg(aw_addr_reg, TX_BUF_OFF) && lo_en;
   assign wr_cfg  = wr_fire && (aw_addr_reg == CFG_ADDR);
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         cfg_reg <= CFG_RESET;
         {rx_ie_reg, ds_ie_reg, tx_ie_reg, loop_reg, brk_reg} <= 5'h00;
         {dtr_reg, rts_reg, sec_tx_reg} <= 3'h0;
      end else begin
         if (wr_cfg && lo_en) cfg_reg[7:0] <= w_data_reg[7:0];
         if (wr_cfg && hi_en) cfg_reg[15:8] <= w_data_reg[15:8];
         if (wr_receive_control_status && lo_en) begin
            rx_ie_reg  <= w_data_reg[RX_IE_BIT];
            ds_ie_reg  <= MODEM_EN & w_data_reg[RX_DS_IE_BIT];
            sec_tx_reg <= MODEM_EN & w_data_reg[RX_SEC_TX_BIT];
            rts_reg    <= MODEM_EN & w_data_reg[RX_RTS_BIT];
            dtr_reg    <= MODEM_EN & w_data_reg[RX_DTR_BIT];
         end
         if (wr_transmit_control_status && lo_en) begin
            tx_ie_reg <= w_data_reg[TX_IE_BIT];
            loop_reg  <= w_data_reg[TX_LOOP_BIT];
            brk_reg   <= BREAK_EN & w_data_reg[TX_BRK_BIT];
         end
      end
   end
   assign modem_dtr    = dtr_reg;
   assign modem_rts    = rts_reg;
   assign modem_sec_tx = sec_tx_reg;
   assign br_level     = BR_LEVEL;
   // ==========================
   // Baud generator: eight rates, 16x ticks
   function automatic logic [15:0] rate_div(input logic [2:0] sel);
      rate_div = DIV_BASE << sel;
   endfunction : rate_div
   logic [15:0] tx_cnt_reg, rx_cnt_reg;
   logic        tx_tick, rx_tick, rx_wrap;
   logic [2:0]  rx_sel;
   assign rx_sel  = loop_reg ? cfg_reg[CFG_TXB_LSB+:3] : cfg_reg[CFG_RXB_LSB+:3];
   assign tx_tick = (tx_cnt_reg == 16'h0000);
   assign rx_wrap = (rx_cnt_reg == 16'h0000);
   // Loopback borrows the transmit tick so both ends share one bit clock
   assign rx_tick = loop_reg ? tx_tick : rx_wrap;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         tx_cnt_reg <= 16'h0000;
         rx_cnt_reg <= 16'h0000;
      end else begin
         tx_cnt_reg <= tx_tick ? rate_div(cfg_reg[CFG_TXB_LSB+:3]) - 16'h0001
                               : tx_cnt_reg - 16'h0001;
         rx_cnt_reg <= rx_wrap ? rate_div(rx_sel) - 16'h0001 : rx_cnt_reg - 16'h0001;
      end
   end
   // ==========================
   // Transmitter: holding buffer plus shifter
   tx_state_t   tx_state_reg;
   logic [7:0]  tx_shift_reg;
   logic [2:0]  tx_bit_reg;
   logic [4:0]  tx_sub_reg;
   logic        tx_out_reg, tx_par_reg, tx_load;
   logic [2:0]  data_bits;
   logic [4:0]  stop_len;
   // Index of the last data bit: codes 0..3 give 5..8 bits
   assign data_bits = {1'b1, cfg_reg[CFG_LEN_LSB+:2]};
   // Last tick index of the stop period
   assign stop_len  = (cfg_reg[CFG_STOP_LSB+:2] == 2'h0) ? 5'd15 :
                      (cfg_reg[CFG_STOP_LSB+:2] == 2'h1) ? 5'd23 : 5'd31;
   assign tx_load   = tx_tick && (tx_state_reg == TX_IDLE) && hold_full_reg;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         hold_full_reg <= 1'b0;
         tx_hold_reg   <= 8'h00;
      end else begin
         if (wr_transmit_buffer) begin
            hold_full_reg <= 1'b1;
            tx_hold_reg   <= w_data_reg[7:0];
         end else if (tx_load) begin
            hold_full_reg <= 1'b0;
         end
      end
   end
   assign tx_rdy_reg = !hold_full_reg;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= 8'h00;
         tx_bit_reg   <= 3'h0;
         tx_sub_reg   <= 5'h00;
         tx_out_reg   <= 1'b1;
         tx_par_reg   <= 1'b0;
      end else if (tx_tick) begin
         tx_sub_reg <= tx_sub_reg + 5'h01;
         case (tx_state_reg)
            TX_IDLE: begin
               tx_out_reg <= 1'b1;
               if (hold_full_reg) begin
                  tx_shift_reg <= tx_hold_reg;
                  tx_par_reg   <= cfg_reg[CFG_PODD_BIT];
                  tx_state_reg <= TX_START;
                  tx_sub_reg   <= 5'h00;
                  tx_out_reg   <= 1'b0;
               end
            end
            TX_START: if (tx_sub_reg == 5'd15) begin
               tx_state_reg <= TX_DATA;
               tx_bit_reg   <= 3'h0;
               tx_sub_reg   <= 5'h00;
               tx_out_reg   <= tx_shift_reg[0];
            end
            TX_DATA: if (tx_sub_reg == 5'd15) begin
               tx_sub_reg   <= 5'h00;
               tx_par_reg   <= tx_par_reg ^ tx_shift_reg[0];
               tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
               tx_bit_reg   <= tx_bit_reg + 3'h1;
               if (tx_bit_reg == data_bits) begin
                  tx_state_reg <= cfg_reg[CFG_PEN_BIT] ? TX_PAR : TX_STOP;
                  tx_out_reg   <= cfg_reg[CFG_PEN_BIT] ? (tx_par_reg ^ tx_shift_reg[0]) : 1'b1;
               end else begin
                  tx_out_reg <= tx_shift_reg[1];
               end
            end
            TX_PAR: if (tx_sub_reg == 5'd15) begin
               tx_sub_reg   <= 5'h00;
               tx_state_reg <= TX_STOP;
               tx_out_reg   <= 1'b1;
            end
            TX_STOP: if (tx_sub_reg == stop_len) begin
               tx_state_reg <= TX_IDLE;
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end
   // Break forces space while pacing continues unchanged
   assign tx_line = tx_out_reg && !brk_reg;
   // ==========================
   // Receiver
   rx_state_t  rx_state_reg;
   logic [7:0] rx_shift_reg;
   logic [2:0] rx_bit_reg;
   logic [3:0] rx_sub_reg;
   logic       rx_par_reg, rx_in, rx_deliver;
   logic [3:0] rx_err_next;
   assign rx_in = loop_reg ? tx_out_reg : pin_s2_reg[0];
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rx_state_reg <= RX_IDLE;
         rx_shift_reg <= 8'h00;
         rx_bit_reg   <= 3'h0;
         rx_sub_reg   <= 4'h0;
         rx_par_reg   <= 1'b0;
      end else if (rx_tick) begin
         rx_sub_reg <= rx_sub_reg + 4'h1;
         case (rx_state_reg)
            RX_IDLE: if (!rx_in) begin
               rx_state_reg <= RX_START;
               rx_sub_reg   <= 4'h0;
            end
            RX_START: if (rx_sub_reg == 4'd7) begin
               rx_state_reg <= rx_in ? RX_IDLE : RX_DATA;
               rx_sub_reg   <= 4'h0;
               rx_bit_reg   <= 3'h0;
               rx_shift_reg <= 8'h00;
               rx_par_reg   <= cfg_reg[CFG_PODD_BIT];
            end
            RX_DATA: if (rx_sub_reg == 4'd15) begin
               rx_shift_reg[rx_bit_reg] <= rx_in;
               rx_par_reg <= rx_par_reg ^ rx_in;
               rx_bit_reg <= rx_bit_reg + 3'h1;
               if (rx_bit_reg == data_bits) begin
                  rx_state_reg <= cfg_reg[CFG_PEN_BIT] ? RX_PAR : RX_STOP;
               end
            end
            RX_PAR: if (rx_sub_reg == 4'd15) begin
               rx_par_reg   <= rx_par_reg ^ rx_in;
               rx_state_reg <= RX_STOP;
            end
            RX_STOP: if (rx_sub_reg == 4'd15) begin
               rx_state_reg <= RX_IDLE;
            end
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end
   assign rx_deliver = rx_tick && (rx_state_reg == RX_STOP) && (rx_sub_reg == 4'd15);
   // Error status: overrun, framing, parity
   always_comb begin
      rx_err_next[2] = rx_done_reg;
      rx_err_next[1] = !rx_in;
      rx_err_next[0] = cfg_reg[CFG_PEN_BIT] && rx_par_reg;
      rx_err_next[3] = |rx_err_next[2:0];
   end
   // Reading the receive buffer clears done
   logic rd_rbuf;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rx_done_reg <= 1'b0;
         rx_data_reg <= 8'h00;
         rx_err_reg  <= 4'h0;
      end else begin
         if (rx_deliver) begin
            rx_done_reg <= 1'b1;
            rx_data_reg <= rx_shift_reg;
            rx_err_reg  <= rx_err_next;
         end else if (rd_rbuf) begin
            rx_done_reg <= 1'b0;
         end
      end
   end
   // ==========================
   // Modem status change interrupt flag
   logic ds_change;
   // Samples taken before the synchroniser filled are not a change
   assign ds_change = MODEM_EN && (pin_age_reg == 2'h3) &&
                      (pin_s2_reg[4:1] != pin_prev_reg[4:1]);
   logic rd_receive_control_status;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ds_int_reg <= 1'b0;
      end else if (ds_change) begin
         ds_int_reg <= 1'b1;
      end else if (rd_receive_control_status) begin
         ds_int_reg <= 1'b0;
      end
   end
   assign rx_irq    = rx_done_reg && rx_ie_reg;
   assign tx_irq    = tx_rdy_reg && tx_ie_reg;
   assign modem_irq = ds_int_reg && ds_ie_reg;
   // ==========================
   // Read channel
   logic [15:0] receive_control_status_val, rbuf_val, transmit_control_status_val, rd_val;
   always_comb begin
      receive_control_status_val = 16'h0000;
      receive_control_status_val[RX_DS_INT_BIT] = ds_int_reg;
      receive_control_status_val[RX_RING_BIT]   = MODEM_EN & pin_s2_reg[3];
      receive_control_status_val[RX_CTS_BIT]    = MODEM_EN & pin_s2_reg[4];
      receive_control_status_val[RX_CD_BIT]     = MODEM_EN & pin_s2_reg[2];
      receive_control_status_val[RX_SEC_RX_BIT] = MODEM_EN & pin_s2_reg[1];
      receive_control_status_val[RX_DONE_BIT]   = rx_done_reg;
      receive_control_status_val[RX_IE_BIT]     = rx_ie_reg;
      receive_control_status_val[RX_DS_IE_BIT]  = ds_ie_reg;
      receive_control_status_val[RX_SEC_TX_BIT] = sec_tx_reg;
      receive_control_status_val[RX_RTS_BIT]    = rts_reg;
      receive_control_status_val[RX_DTR_BIT]    = dtr_reg;
      rbuf_val = {rx_err_reg, 4'h0, rx_data_reg};
      transmit_control_status_val = 16'h0000;
      transmit_control_status_val[TX_RDY_BIT]  = tx_rdy_reg;
      transmit_control_status_val[TX_IE_BIT]   = tx_ie_reg;
      transmit_control_status_val[TX_LOOP_BIT] = loop_reg;
      transmit_control_status_val[TX_BRK_BIT]  = brk_reg;
      if (is_reg(ar_addr_reg, RX_CSR_OFF)) begin
         rd_val = receive_control_status_val;
      end else if (is_reg(ar_addr_reg, RX_BUF_OFF)) begin
         rd_val = rbuf_val;
      end else if (is_reg(ar_addr_reg, TX_CSR_OFF)) begin
         rd_val = transmit_control_status_val;
      end else if (ar_addr_reg == CFG_ADDR) begin
         rd_val = cfg_reg;
      end else begin
         rd_val = 16'h0000;
      end
   end
   logic ar_hold_reg;
   assign s_axi_arready = !ar_hold_reg && !s_axi_rvalid;
   assign rd_fire = ar_hold_reg;
   assign rd_rbuf = rd_fire && is_reg(ar_addr_reg, RX_BUF_OFF);
   assign rd_receive_control_status = rd_fire && is_reg(ar_addr_reg, RX_CSR_OFF);
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ar_hold_reg  <= 1'b0;
         ar_addr_reg  <= 8'h00;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            ar_hold_reg <= 1'b1;
            ar_addr_reg <= s_axi_araddr;
         end
         if (rd_fire) begin
            ar_hold_reg  <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0000, rd_val};
            s_axi_rresp  <= (ar_addr_reg > CFG_ADDR) ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : async_line_interface

// ---- inc/async_line_pkg.sv ----
// Constants and types for the asynchronous line interface
package async_line_pkg;
   // ==========================
   // Register byte offsets
   localparam logic [3:0] RX_CSR_OFF  = 4'h0;
   localparam logic [3:0] RX_BUF_OFF  = 4'h4;
   localparam logic [3:0] TX_CSR_OFF  = 4'h8;
   localparam logic [3:0] TX_BUF_OFF  = 4'hC;
   localparam logic [3:0] CFG_OFF     = 4'h0;
   localparam logic [7:0] CFG_ADDR    = 8'h10;
   // ==========================
   // Receive control/status bit positions
   localparam int RX_DS_INT_BIT   = 15;
   localparam int RX_RING_BIT     = 14;
   localparam int RX_CTS_BIT      = 13;
   localparam int RX_CD_BIT       = 12;
   localparam int RX_SEC_RX_BIT   = 10;
   localparam int RX_DONE_BIT     = 7;
   localparam int RX_IE_BIT       = 6;
   localparam int RX_DS_IE_BIT    = 5;
   localparam int RX_SEC_TX_BIT   = 3;
   localparam int RX_RTS_BIT      = 2;
   localparam int RX_DTR_BIT      = 1;
   // Receive buffer error bits
   localparam int RB_ERR_BIT      = 15;
   localparam int RB_OVR_BIT      = 14;
   localparam int RB_FRM_BIT      = 13;
   localparam int RB_PAR_BIT      = 12;
   // Transmit control/status bit positions
   localparam int TX_RDY_BIT      = 7;
   localparam int TX_IE_BIT       = 6;
   localparam int TX_LOOP_BIT     = 2;
   localparam int TX_BRK_BIT      = 0;
   // Configuration register fields
   localparam int CFG_TXB_LSB     = 0;
   localparam int CFG_RXB_LSB     = 4;
   localparam int CFG_LEN_LSB     = 8;
   localparam int CFG_PEN_BIT     = 10;
   localparam int CFG_PODD_BIT    = 11;
   localparam int CFG_STOP_LSB    = 12;
   // ==========================
   // Reset values and counts
   localparam logic [15:0] CFG_RESET  = 16'h0377;
   localparam logic [7:0]  BREAK_CHAR = 8'h00;
   localparam int          OVS        = 16;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage : async_line_pkg
